// ---- verilog/sqstk_pkg.sv ----
// Functional notes
// - Bit 15 selects direction: zero reads the entry, one writes it.
// - Bits 14 to 9 hold the entry's own address; reset to that address.
// - Return control zero: advance to the next entry after conversion ends.
// - Return control one: jump back to the first entry after conversion ends.
// - Bits 7 to 4 select converter B channel for the step.
// - Bits 3 to 0 select converter A channel for the step.
// - Entry 28 at 0x3C, reset value 0x7800.
// - Entry 29 at 0x3D, reset value 0x7A00, address field 111101b.
// - Entry 30 at 0x3E, reset value 0x7C00, address field 111110b.
// - Entry 31, last of the stack, at 0x3F, reset value 0x7E00.
package sqstk_pkg;

   localparam int          SQSTK_NUM_ENTRIES = 4;
   localparam logic [5:0]  SQSTK_INDEX_28    = 6'h3c;
   localparam logic [5:0]  SQSTK_INDEX_29    = 6'h3d;
   localparam logic [5:0]  SQSTK_INDEX_30    = 6'h3e;
   localparam logic [5:0]  SQSTK_INDEX_31    = 6'h3f;
   localparam logic [5:0]  SQSTK_FIRST_INDEX = SQSTK_INDEX_28;

   // Byte address is four times the register index
   localparam logic [11:0] SQSTK_ADDR_28     = {4'h0, SQSTK_INDEX_28, 2'h0};
   localparam logic [11:0] SQSTK_ADDR_31     = {4'h0, SQSTK_INDEX_31, 2'h0};

   localparam logic [15:0] SQSTK_RESET_28    = 16'h7800;
   localparam logic [15:0] SQSTK_RESET_29    = 16'h7a00;
   localparam logic [15:0] SQSTK_RESET_30    = 16'h7c00;
   localparam logic [15:0] SQSTK_RESET_31    = 16'h7e00;

   localparam int          SQSTK_DIR_BIT     = 15;
   localparam int          SQSTK_TADDR_MSB   = 14;
   localparam int          SQSTK_TADDR_LSB   = 9;
   localparam int          SQSTK_RET_BIT     = 8;
   localparam int          SQSTK_CHB_MSB     = 7;
   localparam int          SQSTK_CHB_LSB     = 4;
   localparam int          SQSTK_CHA_MSB     = 3;
   localparam int          SQSTK_CHA_LSB     = 0;

   typedef struct packed {
      logic       access_direction;
      logic [5:0] target_address_field;
      logic       stack_return_control;
      logic [3:0] second_converter_channel;
      logic [3:0] first_converter_channel;
   } sqstk_entry_t;

   typedef struct packed {
      logic [3:0] first_converter_channel;
      logic [3:0] second_converter_channel;
      logic [1:0] step;
   } sqstk_step_t;

   typedef enum logic [1:0] {
      SQSTK_IDLE   = 2'b00,
      SQSTK_SETUP  = 2'b01,
      SQSTK_ACCESS = 2'b10
   } sqstk_apb_state_t;

endpackage : sqstk_pkg

// ---- verilog/sqstk_entry.sv ----
`timescale 1ns/100ps
// One 16-bit stack entry with its own reset value
module sqstk_entry
   import sqstk_pkg::*;
#(
   parameter logic [15:0] RESET_VALUE = 16'h0000
) (
   input  wire logic         clk,
   input  wire logic         rst_n,
   input  wire logic         wr_en,
   input  wire logic [15:0]  wr_data,
   output sqstk_entry_t      value
);

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         value <= sqstk_entry_t'(RESET_VALUE);
      end else if (wr_en) begin
         value <= sqstk_entry_t'(wr_data);
      end
   end

endmodule : sqstk_entry

// ---- verilog/sqstk_stepper.sv ----
`timescale 1ns/100ps
// Walks the stack one step per finished conversion
module sqstk_stepper
   import sqstk_pkg::*;
#(
   parameter int ENTRIES = SQSTK_NUM_ENTRIES
) (
   input  wire logic                clk,
   input  wire logic                rst_n,
   input  wire logic                restart,
   input  wire logic                conv_done,
   input  wire logic                ret_ctrl,
   output logic [$clog2(ENTRIES)-1:0] step
);

   localparam int SW = $clog2(ENTRIES);
   localparam logic [SW-1:0] LAST = SW'(ENTRIES - 1);

   logic [SW-1:0] next_step;

   // A stack of one entry leaves no step counter to walk
   if (ENTRIES < 2) begin : g_bad_entries
      $error("sqstk_stepper needs at least two entries");
   end

   // Past the last entry the stack wraps to the first one
   assign next_step = restart                  ? '0 :
                      !conv_done               ? step :
                      ret_ctrl                 ? '0 :
                      (step == LAST)           ? '0 :
                                                 step + SW'(1);

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         step <= '0;
      end else begin
         step <= next_step;
      end
   end

endmodule : sqstk_stepper

// ---- verilog/sqstk_bank.sv ----
// Design decision made here: the APB slave port.
`timescale 1ns/100ps
module sqstk_bank
   import sqstk_pkg::*;
#(
   parameter int ENTRIES = SQSTK_NUM_ENTRIES
) (
   input  wire logic        CORE_CLK,
   input  wire logic        RST_N,
   input  wire logic        PSEL,
   input  wire logic        PENABLE,
   input  wire logic        PWRITE,
   input  wire logic [11:0] PADDR,
   input  wire logic [31:0] PWDATA,
   output logic      [31:0] PRDATA,
   output logic             PREADY,
   output logic             PSLVERR,
   input  wire logic        SEQ_RESTART,
   input  wire logic        CONV_DONE,
   output logic      [3:0]  CHANNEL_A,
   output logic      [3:0]  CHANNEL_B,
   output logic      [1:0]  ACTIVE_STEP
);

   // The four entries are wired by hand below, so no other count can elaborate
   if (ENTRIES != SQSTK_NUM_ENTRIES) begin : g_bad_entries
      $error("sqstk_bank serves exactly four entries");
   end

   ////////////////////////////////////////////////////////////////////////
   // Address decode

   function automatic logic [2:0] sqstk_decode(input logic [11:0] addr);
      logic [2:0] res;
      res = 3'h4;
      if (addr[1:0] != 2'h0) begin
         res = 3'h4;
      end else if (addr == {4'h0, SQSTK_INDEX_28, 2'h0}) begin
         res = 3'h0;
      end else if (addr == {4'h0, SQSTK_INDEX_29, 2'h0}) begin
         res = 3'h1;
      end else if (addr == {4'h0, SQSTK_INDEX_30, 2'h0}) begin
         res = 3'h2;
      end else if (addr == {4'h0, SQSTK_INDEX_31, 2'h0}) begin
         res = 3'h3;
      end
      return res;
   endfunction : sqstk_decode

   wire logic [2:0] sel;
   wire logic       hit;
   wire logic       setup;
   wire logic       wr_strobe;
   wire logic       rd_strobe;

   assign sel       = sqstk_decode(PADDR);
   assign hit       = !sel[2];
   assign setup     = PSEL && !PENABLE;
   assign wr_strobe = setup && PWRITE && hit;
   assign rd_strobe = setup && !PWRITE;

   ////////////////////////////////////////////////////////////////////////
   // Storage

   sqstk_entry_t entry [SQSTK_NUM_ENTRIES];
   logic [15:0]  wr_word;

   // Bit 15 is stored as written; the direction meaning is the host's
   assign wr_word = PWDATA[15:0];

   sqstk_entry #(.RESET_VALUE(SQSTK_RESET_28)) u_e28 (
      .clk     (CORE_CLK),
      .rst_n   (RST_N),
      .wr_en   (wr_strobe && sel == 3'h0),
      .wr_data (wr_word),
      .value   (entry[0])
   );
   sqstk_entry #(.RESET_VALUE(SQSTK_RESET_29)) u_e29 (
      .clk     (CORE_CLK),
      .rst_n   (RST_N),
      .wr_en   (wr_strobe && sel == 3'h1),
      .wr_data (wr_word),
      .value   (entry[1])
   );
   sqstk_entry #(.RESET_VALUE(SQSTK_RESET_30)) u_e30 (
      .clk     (CORE_CLK),
      .rst_n   (RST_N),
      .wr_en   (wr_strobe && sel == 3'h2),
      .wr_data (wr_word),
      .value   (entry[2])
   );
   sqstk_entry #(.RESET_VALUE(SQSTK_RESET_31)) u_e31 (
      .clk     (CORE_CLK),
      .rst_n   (RST_N),
      .wr_en   (wr_strobe && sel == 3'h3),
      .wr_data (wr_word),
      .value   (entry[3])
   );

   ////////////////////////////////////////////////////////////////////////
   // APB answer: one wait-free access phase, registered outputs

   wire logic [31:0] next_prdata;
   wire logic        next_pslverr;

   assign next_prdata  = (rd_strobe && hit) ? {16'h0000, 16'(entry[sel[1:0]])} : 32'h0000_0000;
   assign next_pslverr = setup && !hit;

   always_ff @(posedge CORE_CLK or negedge RST_N) begin
      if (!RST_N) begin
         PRDATA  <= 32'h0000_0000;
         PREADY  <= 1'b0;
         PSLVERR <= 1'b0;
      end else begin
         PRDATA  <= next_prdata;
         PREADY  <= setup;
         PSLVERR <= next_pslverr;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Sequencer stepping

   logic [1:0]   step;
   sqstk_entry_t active;

   assign active = entry[step];

   sqstk_stepper #(.ENTRIES(ENTRIES)) u_stepper (
      .clk       (CORE_CLK),
      .rst_n     (RST_N),
      .restart   (SEQ_RESTART),
      .conv_done (CONV_DONE),
      .ret_ctrl  (active.stack_return_control),
      .step      (step)
   );

   always_ff @(posedge CORE_CLK or negedge RST_N) begin
      if (!RST_N) begin
         CHANNEL_A   <= 4'h0;
         CHANNEL_B   <= 4'h0;
         ACTIVE_STEP <= 2'h0;
      end else begin
         CHANNEL_A   <= active.first_converter_channel;
         CHANNEL_B   <= active.second_converter_channel;
         ACTIVE_STEP <= step;
      end
   end

endmodule : sqstk_bank

// ---- test/sqstk_asserts.sv ----
`timescale 1ns/100ps
module sqstk_asserts
   import sqstk_pkg::*;
(
   input wire logic        CORE_CLK,
   input wire logic        RST_N,
   input wire logic        PSEL,
   input wire logic        PENABLE,
   input wire logic        PWRITE,
   input wire logic [11:0] PADDR,
   input wire logic [31:0] PWDATA,
   input wire logic [31:0] PRDATA,
   input wire logic        PREADY,
   input wire logic        PSLVERR,
   input wire logic        SEQ_RESTART,
   input wire logic        CONV_DONE,
   input wire logic [3:0]  CHANNEL_A,
   input wire logic [3:0]  CHANNEL_B,
   input wire logic [1:0]  ACTIVE_STEP
);
   logic [15:0] sh [4];
   wire         setup = PSEL && !PENABLE;
   wire         hit   = PADDR[11:4] == 8'h0f && PADDR[1:0] == 2'h0;
   wire         quiet = !CONV_DONE && !SEQ_RESTART;
   // Shadow copy of the entries
   always_ff @(posedge CORE_CLK or negedge RST_N) begin
      if (!RST_N)
         sh <= '{SQSTK_RESET_28, SQSTK_RESET_29, SQSTK_RESET_30, SQSTK_RESET_31};
      else if (setup && PWRITE && hit)
         sh[PADDR[3:2]] <= PWDATA[15:0];
   end
   default clocking @(posedge CORE_CLK); endclocking
   default disable iff (!RST_N);
   a_ready_next: assert property (setup |=> PREADY) else $error("late ready");
   a_ready_pulse: assert property (PREADY |=> !PREADY) else $error("long ready");
   a_err_decode: assert property (setup |=> PSLVERR == !hit) else $error("bad slverr");
   a_read_data: assert property (setup && !PWRITE |=> PRDATA == (hit ? {16'h0000, sh[PADDR[3:2]]} : 32'h0))
      else $error("bad read data");
   a_step_next: assert property (CONV_DONE && !SEQ_RESTART && $past(quiet) && !sh[ACTIVE_STEP][8]
      |-> ##2 ACTIVE_STEP == $past(ACTIVE_STEP, 2) + 2'h1) else $error("no advance");
   a_step_first: assert property (CONV_DONE && $past(quiet) && sh[ACTIVE_STEP][8] |-> ##2 ACTIVE_STEP == 2'h0)
      else $error("no return");
   a_restart_first: assert property (SEQ_RESTART ##1 !CONV_DONE |-> ##1 ACTIVE_STEP == 2'h0)
      else $error("no restart");
   a_chan_match: assert property (!$past(PSEL) && $past(quiet) |-> {CHANNEL_B, CHANNEL_A} == sh[ACTIVE_STEP][7:0])
      else $error("channel mismatch");
endmodule : sqstk_asserts

// ---- test/sqstk_host.sv ----
`timescale 1ns/100ps
module sqstk_host (
   input  wire logic        clk,
   input  wire logic        pready,
   input  wire logic [31:0] prdata,
   input  wire logic        pslverr,
   output logic             psel,
   output logic             penable,
   output logic             pwrite,
   output logic [11:0]      paddr,
   output logic [31:0]      pwdata
);
   initial begin
      psel    = 1'b0;
      penable = 1'b0;
      pwrite  = 1'b0;
      paddr   = 12'h000;
      pwdata  = 32'h0;
   end
   // Request held until ready is sampled high, then lines scrambled
   task apb_xfer(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] r, output logic e);
      @(posedge clk);
      psel    <= 1'b1;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge clk);
      penable <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1);
      r = prdata;
      e = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      paddr   <= ~a;
      pwdata  <= ~d;
   endtask : apb_xfer
endmodule : sqstk_host

// ---- test/sqstk_bank_test.sv ----
`timescale 1ns/100ps
module sqstk_bank_test
   import sqstk_pkg::*;
;
   logic        CORE_CLK = 1'b0;
   logic        RST_N = 1'b0;
   logic        SEQ_RESTART = 1'b0;
   logic        CONV_DONE = 1'b0;
   logic        PSEL, PENABLE, PWRITE, PREADY, PSLVERR, er;
   logic [11:0] PADDR;
   logic [31:0] PWDATA, PRDATA, rd;
   logic [3:0]  CHANNEL_A, CHANNEL_B;
   logic [1:0]  ACTIVE_STEP;
   int          err_total = 0;
   int          compares = 0;
   // Rows: byte address, reset value, value written
   logic [43:0] rows [4] = '{44'h0f0_7800_7845, 44'h0f4_7a00_7a67, 44'h0f8_7c00_fd89, 44'h0fc_7e00_7eab};
   sqstk_bank dut (.CORE_CLK(CORE_CLK), .RST_N(RST_N), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
                   .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
                   .SEQ_RESTART(SEQ_RESTART), .CONV_DONE(CONV_DONE), .CHANNEL_A(CHANNEL_A),
                   .CHANNEL_B(CHANNEL_B), .ACTIVE_STEP(ACTIVE_STEP));
   sqstk_host host (.clk(CORE_CLK), .pready(PREADY), .prdata(PRDATA), .pslverr(PSLVERR), .psel(PSEL),
                    .penable(PENABLE), .pwrite(PWRITE), .paddr(PADDR), .pwdata(PWDATA));
   ////////////////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         err_total++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   task automatic print_verdict();
      $display("compares=%0d err_total=%0d", compares, err_total);
      if (err_total == 0 && compares > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : print_verdict
   task automatic pulse(input logic r, input logic [1:0] s, input logic [7:0] ch);
      @(posedge CORE_CLK);
      CONV_DONE   <= ~r;
      SEQ_RESTART <= r;
      @(posedge CORE_CLK);
      CONV_DONE   <= 1'b0;
      SEQ_RESTART <= 1'b0;
      repeat (2) @(posedge CORE_CLK);
      #1;
      chk(32'(ACTIVE_STEP), 32'(s));
      chk(32'({CHANNEL_B, CHANNEL_A}), 32'(ch));
   endtask : pulse
   ////////////////////////////////////////////////////////////////////////////////
   initial forever #10 CORE_CLK = ~CORE_CLK;
   initial begin
      #200000;
      err_total++;
      print_verdict();
   end
   initial begin
      repeat (3) @(posedge CORE_CLK);
      RST_N <= 1'b1;
      foreach (rows[i]) begin
         host.apb_xfer(1'b0, rows[i][43:32], 32'h0, rd, er);
         chk(rd, {16'h0, rows[i][31:16]});
         host.apb_xfer(1'b1, rows[i][43:32], {16'hffff, rows[i][15:0]}, rd, er);
         host.apb_xfer(1'b0, rows[i][43:32], 32'h0, rd, er);
         chk(rd, {16'h0, rows[i][15:0]});
      end
      pulse(1'b0, 2'h1, 8'h67);
      pulse(1'b0, 2'h2, 8'h89);
      pulse(1'b0, 2'h0, 8'h45);
      host.apb_xfer(1'b1, 12'h0f8, 32'h7c89, rd, er);
      for (int s = 1; s < 5; s++)
         pulse(1'b0, 2'(s), rows[s % 4][7:0]);
      pulse(1'b0, 2'h1, 8'h67);
      pulse(1'b1, 2'h0, 8'h45);
      host.apb_xfer(1'b1, 12'h100, 32'h1234, rd, er);
      chk(32'(er), 32'h1);
      host.apb_xfer(1'b0, 12'h0f2, 32'h0, rd, er);
      chk(32'(er), 32'h1);
      chk(rd, 32'h0);
      host.apb_xfer(1'b0, 12'h0f0, 32'h0, rd, er);
      chk(rd, 32'h7845);
      // Leave the stepper away from the first entry so the reset below has work to do
      pulse(1'b0, 2'h1, 8'h67);
      RST_N <= 1'b0;
      repeat (3) @(posedge CORE_CLK);
      RST_N <= 1'b1;
      host.apb_xfer(1'b0, 12'h0fc, 32'h0, rd, er);
      chk(rd, 32'h7e00);
      chk(32'(ACTIVE_STEP), 32'h0);
      chk(32'({CHANNEL_B, CHANNEL_A}), 32'h0);
      print_verdict();
   end
endmodule : sqstk_bank_test
bind sqstk_bank sqstk_asserts u_chk (.CORE_CLK(CORE_CLK), .RST_N(RST_N), .PSEL(PSEL), .PENABLE(PENABLE),
                                     .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA),
                                     .PREADY(PREADY), .PSLVERR(PSLVERR), .SEQ_RESTART(SEQ_RESTART),
                                     .CONV_DONE(CONV_DONE), .CHANNEL_A(CHANNEL_A), .CHANNEL_B(CHANNEL_B),
                                     .ACTIVE_STEP(ACTIVE_STEP));
